// [logic/csp_consts.svh]
// constants for the codec serial port control block
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define CSP_CTRL2_OFS     8'h00
`define CSP_TXDATA_OFS    8'h04
`define CSP_RXDATA_OFS    8'h08
`define CSP_STATUS_OFS    8'h0C

// ------------------------------------------------------------------
// control register 2 fields and reset value
// ------------------------------------------------------------------
`define CSP_CTRL_EN_BIT     0
`define CSP_CTRL_PHONE_BIT  1
`define CSP_CTRL_FLAG0_BIT  2
`define CSP_CTRL_FLAG1_BIT  3
`define CSP_CTRL_W          4
`define CSP_CTRL_RST        4'h0

// ------------------------------------------------------------------
// status fields
// ------------------------------------------------------------------
`define CSP_ST_FC_BIT       0
`define CSP_ST_SLEEP_BIT    1
`define CSP_ST_RXNEW_BIT    2
`define CSP_ST_CNT_LSB      8

// ------------------------------------------------------------------
// link timing, in shift clock cycles
// ------------------------------------------------------------------
`define CSP_WORD_BITS       16
`define CSP_LAST_BIT        4'hF
`define CSP_GAP_CYCLES      6'h08
`define CSP_DATA_RST        16'h0000

`endif

// [logic/csp_pkg.sv]
// types shared by the codec serial port control block
package csp_pkg;

  // link frame sequencer states
  typedef enum logic [1:0] {
    CSP_IDLE = 2'b00,
    CSP_PRI  = 2'b01,
    CSP_SEC  = 2'b10
  } csp_link_state_t;

  typedef logic [15:0] csp_word_t;

endpackage

// [logic/csp_serial_port.sv]
// codec serial port control: ahb-lite registers plus framed serial link
//
// What this block does
// - function select is latched as frame sync rises; it picks secondary
// - in phone mode both user outputs follow their bits of control register 2
// - serial port is active only while frame sync is driven low
// - frame sync stays low for every bit shifted in any mode
// - sleep request low stops the link and disables the serial interface
// - registers survive sleep; operation resumes without host reinitialisation
// - sleep request clears only the internal counters and the pending secondary request, never register contents
// - bus side timing comes from the reference clock input; the link runs on the shift clock
// - serial out is released outside frames, driven with shift clock inside
// - secondary frames in phone mode copy alternate serial in to serial out
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
`include "csp_consts.svh"

module csp_serial_port (
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic                i_hsel,
  input  wire logic [31:0]         i_haddr,
  input  wire logic [1:0]          i_htrans,
  input  wire logic                i_hwrite,
  input  wire logic [2:0]          i_hsize,
  input  wire logic                i_hready,
  input  wire logic [31:0]         i_hwdata,
  output logic                     o_hreadyout,
  output logic                     o_hresp,
  output logic      [31:0]         o_hrdata,
  input  wire logic                i_shift_clk,
  input  wire logic                i_serial_in,
  input  wire logic                i_function_select_in,
  input  wire logic                i_alternate_serial_in,
  input  wire logic                i_sleep_request_n,
  output logic                     o_frame_sync_n,
  output logic                     o_serial_out,
  output logic                     o_serial_out_en,
  output logic                     o_user_output_0,
  output logic                     o_user_output_1,
  output csp_pkg::csp_link_state_t o_link_state
);
  import csp_pkg::*;

  // ----------------------------------------------------------------
  // register bus slave (i_sys_clk is the reference clock)
  // ----------------------------------------------------------------

  // one-hot register select, shared by the read and write paths
  function automatic logic [3:0] reg_sel(input logic [31:0] addr);
    reg_sel = 4'h0;
    if (addr[31:8] == 24'h000000) begin
      reg_sel[0] = (addr[7:0] == `CSP_CTRL2_OFS);
      reg_sel[1] = (addr[7:0] == `CSP_TXDATA_OFS);
      reg_sel[2] = (addr[7:0] == `CSP_RXDATA_OFS);
      reg_sel[3] = (addr[7:0] == `CSP_STATUS_OFS);
    end
  endfunction

  logic                    addr_ph;
  logic                    wr_pend;
  logic [3:0]              wr_sel;
  logic [`CSP_CTRL_W-1:0]  ctrl;
  csp_word_t               tx_hold;
  logic                    tx_tgl;
  csp_word_t               rx_data;
  logic                    fc_stat;
  logic                    rx_new;
  logic [7:0]              frame_cnt;
  logic [2:0]              done_s;
  logic [1:0]              sleep_s;
  logic                    done_evt;
  logic                    rx_read;
  // decoded select and link results that the bus side reads
  logic [3:0]              sel_now;
  csp_word_t               rx_word;
  logic                    fc_lat;
  logic                    done_tgl;

  // zero wait states, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign addr_ph     = i_hsel & i_htrans[1] & i_hready;
  assign sel_now     = reg_sel(i_haddr);
  assign rx_read     = addr_ph & ~i_hwrite & sel_now[2];
  assign done_evt    = done_s[2] ^ done_s[1];

  // address phase captured for the write data phase
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_pend <= 1'b0;
      wr_sel  <= 4'h0;
    end else begin
      wr_pend <= addr_ph & i_hwrite;
      wr_sel  <= reg_sel(i_haddr);
    end
  end

  // read data registered during the address phase; unmapped reads zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_hrdata <= 32'h00000000;
    end else if (addr_ph & ~i_hwrite) begin
      unique case (1'b1)
        sel_now[0]: o_hrdata <= {28'h0000000, ctrl};
        sel_now[1]: o_hrdata <= {16'h0000, tx_hold};
        sel_now[2]: o_hrdata <= {16'h0000, rx_data};
        sel_now[3]: o_hrdata <= {16'h0000, frame_cnt,
                                 5'h00, rx_new, sleep_s[1],
                                 fc_stat};
        default:    o_hrdata <= 32'h00000000;
      endcase
    end
  end

  // software registers; sleep never touches them
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl    <= `CSP_CTRL_RST;
      tx_hold <= `CSP_DATA_RST;
      tx_tgl  <= 1'b0;
    end else if (wr_pend) begin
      if (wr_sel[0]) begin
        ctrl <= i_hwdata[`CSP_CTRL_W-1:0];
      end
      if (wr_sel[1]) begin
        tx_hold <= i_hwdata[15:0];
        tx_tgl  <= ~tx_tgl;            // tells the link a new word waits
      end
    end
  end

  // user outputs mirror control register 2 only in phone mode;
  // the pins follow one clock after the data-phase write lands
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_user_output_0 <= 1'b0;
      o_user_output_1 <= 1'b0;
    end else begin
      o_user_output_0 <= ctrl[`CSP_CTRL_PHONE_BIT] &
                         ctrl[`CSP_CTRL_FLAG0_BIT];
      o_user_output_1 <= ctrl[`CSP_CTRL_PHONE_BIT] &
                         ctrl[`CSP_CTRL_FLAG1_BIT];
    end
  end

  // frame-done toggle and sleep pin brought into the bus domain; no
  // reset needed, the link clears its toggle while reset is held
  always_ff @(posedge i_sys_clk) begin
    done_s  <= {done_s[1:0], done_tgl};
    sleep_s <= {sleep_s[0], ~i_sleep_request_n};
  end

  // received word and latched function select, taken once per primary frame
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_data   <= `CSP_DATA_RST;
      fc_stat   <= 1'b0;
      frame_cnt <= 8'h00;
    end else if (done_evt) begin
      rx_data   <= rx_word;               // stable since the toggle
      fc_stat   <= fc_lat;
      frame_cnt <= frame_cnt + 8'h01;
    end
  end

  // new-word flag: a frame finishing in the read cycle keeps it set;
  // reading the received word clears it
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_new <= 1'b0;
    end else if (done_evt) begin
      rx_new <= 1'b1;
    end else if (rx_read) begin
      rx_new <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link side, clocked by the shift clock
  // ----------------------------------------------------------------

  logic [6:0]       ls1;
  logic [6:0]       ls2;
  logic             lrst;
  logic             en_l;
  logic             phone_l;
  logic             sleep_n_l;
  logic             fc_l;
  logic             alt_l;
  logic             sin_l;
  logic [2:0]       tx_s;
  logic             halt;
  csp_link_state_t  state;
  csp_link_state_t  next_state;
  logic [3:0]       bit_cnt;
  logic [5:0]       gap_cnt;
  csp_word_t        tx_shadow;
  csp_word_t        tx_sr;
  csp_word_t        rx_sr;
  logic             sec_pend;
  logic [2:0]       pri_end_d;
  logic             pri_end;
  logic             last_bit;

  // every pin and control-register level passes two flops before use; the
  // control bits are quasi-static, so a bit-wise sync is enough
  always_ff @(posedge i_shift_clk) begin
    ls1  <= {i_rst, ctrl[`CSP_CTRL_EN_BIT], ctrl[`CSP_CTRL_PHONE_BIT],
             i_sleep_request_n, i_function_select_in,
             i_alternate_serial_in, i_serial_in};
    ls2  <= ls1;
    tx_s <= {tx_s[1:0], tx_tgl};
  end

  assign {lrst, en_l, phone_l, sleep_n_l, fc_l, alt_l, sin_l} = ls2;
  // sleep or disable halts the sequencer and its counters
  assign halt     = lrst | ~sleep_n_l | ~en_l;
  assign last_bit = (bit_cnt == `CSP_LAST_BIT);
  assign pri_end  = (state == CSP_PRI) & last_bit;
  assign o_link_state = state;

  // frame sequencer: gap, primary word, gap, optional secondary word;
  // each word has its own frame sync pulse so the select meets a rise
  always_comb begin
    next_state = state;
    if (halt) begin
      next_state = CSP_IDLE;
    end else begin
      unique case (state)
        CSP_IDLE: begin
          // a pending secondary word goes out before the next primary
          if (gap_cnt == `CSP_GAP_CYCLES - 6'h01) begin
            next_state = sec_pend ? CSP_SEC : CSP_PRI;
          end
        end
        CSP_PRI: begin
          if (last_bit) begin
            next_state = CSP_IDLE;   // frame sync rises here
          end
        end
        CSP_SEC: begin
          if (last_bit) begin
            next_state = CSP_IDLE;
          end
        end
        default: next_state = CSP_IDLE;
      endcase
    end
  end

  // state and counters; counters restart on halt, so sleep clears
  // only these counters and the pending secondary request, never a software register
  always_ff @(posedge i_shift_clk) begin
    state <= next_state;
    if (halt || next_state != state) begin
      bit_cnt <= 4'h0;
      gap_cnt <= 6'h00;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
      gap_cnt <= gap_cnt + 6'h01;
    end
  end

  // frame sync low and output driven only while a word is shifting
  always_ff @(posedge i_shift_clk) begin
    if (lrst) begin
      o_frame_sync_n  <= 1'b1;
      o_serial_out_en <= 1'b0;
    end else begin
      o_frame_sync_n  <= (next_state == CSP_IDLE);
      o_serial_out_en <= (next_state != CSP_IDLE);
    end
  end

  // serial out: primary carries the word, secondary the alternate pin in phone mode, else zero
  always_ff @(posedge i_shift_clk) begin
    if (lrst) begin
      o_serial_out <= 1'b0;
      tx_sr        <= `CSP_DATA_RST;
    end else if (next_state == CSP_PRI && state != CSP_PRI) begin
      o_serial_out <= tx_shadow[15];
      tx_sr        <= {tx_shadow[14:0], 1'b0};
    end else if (next_state == CSP_PRI) begin
      o_serial_out <= tx_sr[15];
      tx_sr        <= {tx_sr[14:0], 1'b0};
    end else if (next_state == CSP_SEC) begin
      o_serial_out <= phone_l & alt_l;
    end else begin
      o_serial_out <= 1'b0;
    end
  end

  // new word from software; held across sleep
  always_ff @(posedge i_shift_clk) begin
    if (lrst) begin
      tx_shadow <= `CSP_DATA_RST;
    end else if (tx_s[2] ^ tx_s[1]) begin
      tx_shadow <= tx_hold;        // software must not rewrite for 4 clocks
    end
  end

  // host bits shift in every cycle; word taken three cycles after the
  // last primary bit to cover the input synchroniser
  always_ff @(posedge i_shift_clk) begin
    rx_sr <= {rx_sr[14:0], sin_l};
    if (lrst) begin
      pri_end_d <= 3'h0;
      rx_word   <= `CSP_DATA_RST;
      done_tgl  <= 1'b0;
    end else begin
      pri_end_d <= {pri_end_d[1:0], pri_end & ~halt};
      if (pri_end_d[2]) begin
        rx_word  <= rx_sr;
        done_tgl <= ~done_tgl;
      end
    end
  end

  // function select caught as frame sync rises after the primary word
  always_ff @(posedge i_shift_clk) begin
    if (lrst) begin
      fc_lat <= 1'b0;
    end else if (pri_end & ~halt) begin
      fc_lat <= fc_l;
    end
  end

  // secondary request, taken from the select as the primary frame ends;
  // sleep or disable drops it so the link always restarts with a primary
  always_ff @(posedge i_shift_clk) begin
    if (halt) begin
      sec_pend <= 1'b0;
    end else if (pri_end) begin
      sec_pend <= fc_l;
    end else if (next_state == CSP_SEC) begin
      sec_pend <= 1'b0;
    end
  end

  // the bus clock serves as the reference clock; the link runs on the
  // shift clock alone and no divided or gated clock exists anywhere,
  // so sleep stops the link by holding its sequencer, not its clock

endmodule

// [tb/csp_host_model.sv]
// host side serial port model driving the device's serial input
`timescale 1ns/1ns
module csp_host_model (
  input  wire logic        i_shift_clk,
  input  wire logic        i_frame_sync_n,
  input  wire logic [15:0] i_word,
  output logic             o_serial_in
);
  int idx = 0;
  logic bit_q = 1'b0;
  assign o_serial_in = bit_q;
  // one bit per frame-low cycle, msb first; outside that a toggling
  // level so a stale bit can never pass for data
  always @(posedge i_shift_clk) begin
    #1;
    if (!i_frame_sync_n && idx < 16) begin
      bit_q <= i_word[15 - idx];
      idx <= idx + 1;
    end else begin
      bit_q <= ~bit_q;
      if (i_frame_sync_n) idx <= 0;
    end
  end
endmodule

// [tb/csp_serial_port_assertions.sv]
// concurrent checks on the codec serial port control ports
`timescale 1ns/1ns
`include "csp_consts.svh"
module csp_checker
  import csp_pkg::*;
(
  input wire logic            i_sys_clk,
  input wire logic            i_rst,
  input wire logic            i_hsel,
  input wire logic [31:0]     i_haddr,
  input wire logic [1:0]      i_htrans,
  input wire logic            i_hwrite,
  input wire logic            i_hready,
  input wire logic [31:0]     i_hwdata,
  input wire logic            o_hreadyout,
  input wire logic            o_hresp,
  input wire logic            i_shift_clk,
  input wire logic            i_sleep_request_n,
  input wire logic            o_frame_sync_n,
  input wire logic            o_serial_out,
  input wire logic            o_serial_out_en,
  input wire logic            o_user_output_0,
  input wire logic            o_user_output_1,
  input wire csp_link_state_t o_link_state
);
  logic [5:0] low_cnt;
  // ---------------------------------------------------------------
  // helper: frame-low length, cleared whenever frame sync is high
  // ---------------------------------------------------------------
  always_ff @(posedge i_shift_clk) begin
    if (i_rst || o_frame_sync_n) low_cnt <= 6'h00;
    else low_cnt <= low_cnt + 6'h01;
  end
  sequence s_ctrl_adr;
    i_hsel && i_htrans[1] && i_hready && i_hwrite &&
      i_haddr[7:0] == `CSP_CTRL2_OFS;
  endsequence
  property p_user;
    logic [3:0] d;
    @(posedge i_sys_clk) disable iff (i_rst)
      (s_ctrl_adr ##1 (1, d = i_hwdata[3:0])) |-> ##[1:2]
      (o_user_output_0 == (d[2] & d[1]) &&
       o_user_output_1 == (d[3] & d[1]));
  endproperty
  property p_bus;
    @(posedge i_sys_clk) disable iff (i_rst) o_hreadyout && !o_hresp;
  endproperty
  property p_en;
    @(posedge i_shift_clk) disable iff (i_rst)
      o_serial_out_en == !o_frame_sync_n;
  endproperty
  property p_rel;
    @(posedge i_shift_clk) disable iff (i_rst)
      !o_serial_out_en |-> !o_serial_out;
  endproperty
  property p_len;
    @(posedge i_shift_clk) disable iff (i_rst)
      $rose(o_frame_sync_n) && i_sleep_request_n &&
      $past(i_sleep_request_n, 4) |-> low_cnt == 6'h10;
  endproperty
  property p_gap;
    @(posedge i_shift_clk) disable iff (i_rst)
      $rose(o_frame_sync_n) |-> o_frame_sync_n [*8];
  endproperty
  property p_act;
    @(posedge i_shift_clk) disable iff (i_rst)
      !o_frame_sync_n |-> o_link_state != CSP_IDLE;
  endproperty
  property p_sleep;
    @(posedge i_shift_clk) disable iff (i_rst)
      !i_sleep_request_n [*4] |-> o_frame_sync_n;
  endproperty
  a_user:  assert property (p_user)  else $error("user outputs wrong");
  a_bus:   assert property (p_bus)   else $error("bus not ready okay");
  a_en:    assert property (p_en)    else $error("drive enable wrong");
  a_rel:   assert property (p_rel)   else $error("idle data not 0");
  a_len:   assert property (p_len)   else $error("frame length wrong");
  a_gap:   assert property (p_gap)   else $error("frame gap short");
  a_act:   assert property (p_act)   else $error("active while idle");
  a_sleep: assert property (p_sleep) else $error("frame in sleep");
endmodule
bind csp_serial_port csp_checker u_chk (.i_sys_clk, .i_rst, .i_hsel,
  .i_haddr, .i_htrans, .i_hwrite, .i_hready, .i_hwdata, .o_hreadyout,
  .o_hresp, .i_shift_clk, .i_sleep_request_n, .o_frame_sync_n,
  .o_serial_out, .o_serial_out_en, .o_user_output_0, .o_user_output_1,
  .o_link_state);

// [tb/codec_serial_port_control_bench.sv]
// self-checking bench for the codec serial port control block
`timescale 1ns/1ns
`include "csp_consts.svh"
module codec_serial_port_control_bench;
  import csp_pkg::*;
  logic sys_clk = 0, shift_clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv, w;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, sin, fsel = 0, alt = 0, sleep_n = 1;
  logic fs_n, sout, sout_en, uo0, uo1;
  csp_link_state_t lstate;
  int error_cnt = 0, compares = 0, n;
  // both clocks free-run: the idle gap is counted on the shift clock
  always #20 sys_clk = ~sys_clk;
  always #16 shift_clk = ~shift_clk;
  csp_serial_port dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hready(hreadyout), .i_hwdata(hwdata),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_shift_clk(shift_clk), .i_serial_in(sin),
    .i_function_select_in(fsel), .i_alternate_serial_in(alt),
    .i_sleep_request_n(sleep_n), .o_frame_sync_n(fs_n),
    .o_serial_out(sout), .o_serial_out_en(sout_en),
    .o_user_output_0(uo0), .o_user_output_1(uo1), .o_link_state(lstate));
  csp_host_model host (.i_shift_clk(shift_clk), .i_frame_sync_n(fs_n),
    .i_word(16'h3C96), .o_serial_in(sin));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task summarize;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one bounded wait for ready; a timeout closes the run
  task rdy;
    int k;
    k = 0;
    do begin @(posedge sys_clk); #1; k++; end
    while (hreadyout !== 1'b1 && k < 20);
    if (k == 20) begin error_cnt++; summarize(); end
  endtask
  task acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= wr;
    rdy();
    htrans <= 2'b00; hsel <= 0; hwdata <= d;
    rdy();
    rdv = hrdata;
  endtask
  task wait_fs(input logic lvl);
    int k;
    k = 0;
    while (fs_n !== lvl && k < 400) begin @(posedge shift_clk); #1; k++; end
    if (k == 400) begin error_cnt++; summarize(); end
  endtask
  // collect the next whole frame of the given kind, msb first, and its
  // frame-low length; frames of the other kind are skipped
  task grab(input csp_link_state_t st);
    int t;
    t = 0;
    do begin wait_fs(1); wait_fs(0); t++; end
    while (lstate !== st && t < 4);
    chk(lstate, st);
    w = 0; n = 0;
    while (fs_n === 1'b0 && n < 40) begin
      w = {w[30:0], sout}; n++; @(posedge shift_clk); #1;
    end
    chk(sout_en, 0);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_flags;
    for (int i = 0; i < 8; i++) begin
      acc(1, `CSP_CTRL2_OFS, {28'h0, i[2:0], 1'b0});
      acc(0, `CSP_CTRL2_OFS, 0); chk(rdv, {28'h0, i[2:0], 1'b0});
      chk({uo1, uo0}, {i[2] & i[0], i[1] & i[0]});
    end
  endtask
  task t_frame;
    acc(1, `CSP_TXDATA_OFS, 32'h0000A5C3);
    acc(0, `CSP_TXDATA_OFS, 0); chk(rdv, 32'h0000A5C3);
    acc(1, `CSP_CTRL2_OFS, 32'h1);
    grab(CSP_PRI); chk(n, 16); chk(w, 32'h0000A5C3);
    repeat (12) @(posedge shift_clk);
    acc(0, `CSP_RXDATA_OFS, 0); chk(rdv, 32'h00003C96);
    acc(0, `CSP_STATUS_OFS, 0); chk(rdv[0], 0);
  endtask
  task t_second;
    @(posedge sys_clk); fsel <= 1; alt <= 1;
    for (int p = 1; p >= 0; p--) begin
      acc(1, `CSP_CTRL2_OFS, {30'h0, p[0], 1'b1});
      grab(CSP_PRI); chk(n, 16); chk(w, 32'h0000A5C3);
      grab(CSP_SEC); chk(n, 16);
      chk(w, p[0] ? 32'h0000FFFF : 32'h00000000);
    end
    acc(0, `CSP_STATUS_OFS, 0); chk(rdv[0], 1);
  endtask
  task t_sleep;
    @(posedge sys_clk); fsel <= 0; alt <= 0;
    acc(1, `CSP_CTRL2_OFS, 32'hF); wait_fs(1); wait_fs(0);
    @(posedge sys_clk); sleep_n <= 0;
    repeat (4) @(posedge shift_clk); #1; chk(fs_n, 1);
    repeat (8) @(posedge sys_clk);
    acc(0, `CSP_STATUS_OFS, 0); chk(rdv[1], 1);
    acc(0, `CSP_CTRL2_OFS, 0); chk(rdv, 32'hF);
    acc(0, `CSP_TXDATA_OFS, 0); chk(rdv, 32'h0000A5C3);
    chk({uo1, uo0}, 2'b11);
    @(posedge sys_clk); sleep_n <= 1;
    grab(CSP_PRI); chk(n, 16); chk(w, 32'h0000A5C3);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    acc(0, `CSP_CTRL2_OFS, 0); chk(rdv, 32'h0);
    acc(0, 8'h10, 0); chk(rdv, 32'h0);
    t_flags(); t_frame(); t_second(); t_sleep();
    summarize();
  end
endmodule
